// >>> inc/pbsps_pkg.sv
// Constants, register map and carrier type of the port-two pin block
// How it works
// (RQ1) Capture rising edge copies timer-two count and requests the capture interrupt
// (RQ2) Outside source holds the capture input high at least two state times
// (RQ3) Capture interrupt mask bit gates the request; the count is captured anyway
// (RQ4) Output-select bit at zero drives the shared pin from port bit five
// (RQ5) Output-select bit at one drives the shared pin from first PWM output
// (RQ6) First PWM takes duty from its register, frequency from a select bit
// (RQ7) Port offset 10h: bit five written as output, bit four read as input
// (RQ8) Strobe-mode bit one picks write plus high enable, zero split strobes
// (RQ9) Combined mode: write strobe only on external memory writes
// (RQ10) Combined mode: high-byte enable on word writes and high-byte writes
// (RQ11) Split mode: low strobe on low-byte or word writes, always on 8-bit bus
// (RQ12) Split mode 16-bit bus: high strobe on high-byte and word writes
// (RQ13) Split mode 8-bit bus: high strobe on every write
// (RQ14) Capture input synchronised, rising edge found from current and previous sample
package pbsps_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W  = 16;
   localparam int DUTY_W = 8;
   localparam int DIV_W  = 8;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_DUTY    = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CAPTURE = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_PORT    = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h14;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CTRL_OUT_SEL  = 0;
   localparam int CTRL_FREQ_SEL = 1;
   localparam int CTRL_STB_MODE = 2;
   localparam int CTRL_W        = 3;
   localparam int IRQ_CAPTURE   = 0;
   localparam int IRQ_W         = 1;
   localparam int PORT_IN_BIT   = 4;
   localparam int PORT_OUT_BIT  = 5;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [CTRL_W-1:0] RST_CTRL     = 3'h0;
   localparam logic [DUTY_W-1:0] RST_DUTY     = 8'h00;
   localparam logic [IRQ_W-1:0]  RST_MASK     = 1'h0;
   localparam logic              RST_PORT_OUT = 1'h1;

   // ---------------------------------------------------------------
   // Timing and fixed values
   // ---------------------------------------------------------------
   localparam int PWM_DIV_FAST = 1;
   localparam int PWM_DIV_SLOW = 2;
   localparam logic [15:0] CAPTURE_VECTOR = 16'h2036;

   // ---------------------------------------------------------------
   // Carrier of one bus-controller cycle description
   // ---------------------------------------------------------------
   typedef struct packed {
      logic ext;      // Cycle goes to external memory
      logic wr;       // Cycle is a write
      logic wide;     // Bus runs 16 bits wide
      logic word;     // Full word transfer
      logic hi_byte;  // Byte transfer to the odd (high) byte
   } pbsps_bus_t;

endpackage : pbsps_pkg

// >>> core/pbsps_sync.sv
// Three-stage synchroniser for pin inputs, one chain per bit
`timescale 1ns/1ns
module pbsps_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             mclk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] stage_two,
   output logic      [WIDTH-1:0] stage_three
);

   logic [WIDTH-1:0] stage_one_ff;
   logic [WIDTH-1:0] stage_two_ff;
   logic [WIDTH-1:0] stage_three_ff;

   // ---------------------------------------------------------------
   // Per-bit chains; first stage feeds only the second
   // ---------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               stage_one_ff[i]   <= 1'b0;
               stage_two_ff[i]   <= 1'b0;
               stage_three_ff[i] <= 1'b0;
            end else begin
               stage_one_ff[i]   <= async_in[i];
               stage_two_ff[i]   <= stage_one_ff[i];
               stage_three_ff[i] <= stage_two_ff[i];
            end
         end
      end
   endgenerate

   assign stage_two   = stage_two_ff;
   assign stage_three = stage_three_ff;

endmodule : pbsps_sync

// >>> core/pbsps_top.sv
// Port-two pin select, capture, first PWM output and write strobes
`timescale 1ns/1ns
module pbsps_top #(
   parameter int PWM_DIV_FAST = pbsps_pkg::PWM_DIV_FAST,
   parameter int PWM_DIV_SLOW = pbsps_pkg::PWM_DIV_SLOW
) (
   input  wire logic                           mclk,
   input  wire logic                           rstn,
   // APB slave
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [pbsps_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [pbsps_pkg::DATA_W-1:0]   pwdata,
   output logic      [pbsps_pkg::DATA_W-1:0]   prdata,
   output logic                                pready,
   output logic                                pslverr,
   // Internal timer and bus controller
   input  wire logic [pbsps_pkg::CNT_W-1:0]    timer_count,
   input  wire pbsps_pkg::pbsps_bus_t          bus_req,
   // Pins
   input  wire logic                           timer_two_capture_input,
   input  wire logic                           port_two_input_bit_four,
   output logic                                shared_output_pin,
   output logic                                strobe_pin_a_n,
   output logic                                strobe_pin_b_n,
   // Interrupt
   output logic                                capture_interrupt_request,
   output logic      [15:0]                    capture_vector
);

   localparam logic [pbsps_pkg::DIV_W-1:0] DIV_FAST_LIM =
      pbsps_pkg::DIV_W'(PWM_DIV_FAST - 1);
   localparam logic [pbsps_pkg::DIV_W-1:0] DIV_SLOW_LIM =
      pbsps_pkg::DIV_W'(PWM_DIV_SLOW - 1);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [pbsps_pkg::CTRL_W-1:0] ctrl_ff;
   logic [pbsps_pkg::DUTY_W-1:0] duty_ff;
   logic [pbsps_pkg::CNT_W-1:0]  capture_ff;
   logic [pbsps_pkg::IRQ_W-1:0]  status_ff;
   logic [pbsps_pkg::IRQ_W-1:0]  mask_ff;
   logic                         port_out_ff;
   logic [pbsps_pkg::DATA_W-1:0] prdata_ff;
   logic [1:0]                   level_ff;
   logic [pbsps_pkg::DIV_W-1:0]  div_ff;
   logic [pbsps_pkg::DUTY_W-1:0] pwm_cnt_ff;
   logic                         pwm_ff;
   logic                         shared_out_ff;
   logic                         pin_a_n_ff;
   logic                         pin_b_n_ff;

   logic [pbsps_pkg::CTRL_W-1:0] nxt_ctrl;
   logic [pbsps_pkg::DUTY_W-1:0] nxt_duty;
   logic [pbsps_pkg::CNT_W-1:0]  nxt_capture;
   logic [pbsps_pkg::IRQ_W-1:0]  nxt_status;
   logic [pbsps_pkg::IRQ_W-1:0]  nxt_mask;
   logic                         nxt_port_out;
   logic [pbsps_pkg::DATA_W-1:0] nxt_prdata;
   logic [1:0]                   nxt_level;
   logic [pbsps_pkg::DIV_W-1:0]  nxt_div;
   logic [pbsps_pkg::DUTY_W-1:0] nxt_pwm_cnt;
   logic                         nxt_pwm;
   logic                         nxt_shared_out;
   logic                         nxt_pin_a_n;
   logic                         nxt_pin_b_n;

   // ---------------------------------------------------------------
   // Pin input synchronisers and agreement filter
   // ---------------------------------------------------------------
   logic [1:0] sync_two;
   logic [1:0] sync_three;
   logic [1:0] sync_agree;
   logic       capture_edge;
   logic       port_in_level;

   pbsps_sync #(
      .WIDTH       (2)
   ) u_sync (
      .mclk        (mclk),
      .rstn        (rstn),
      .async_in    ({port_two_input_bit_four, timer_two_capture_input}),
      .stage_two   (sync_two),
      .stage_three (sync_three)
   );

   // A change counts only once stages two and three agree
   assign sync_agree   = ~(sync_two ^ sync_three);
   assign nxt_level    = (sync_agree & sync_three) | (~sync_agree & level_ff);
   // Rising edge: agreed new sample high, previous level low
   assign capture_edge = sync_agree[0] & sync_three[0] & ~level_ff[0]; // RQ14
   assign port_in_level = level_ff[1];

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   logic setup_phase;
   logic access_phase;
   logic hit_ctrl;
   logic hit_duty;
   logic hit_capture;
   logic hit_status;
   logic hit_port;
   logic hit_mask;
   logic hit_any;
   logic wr_en;

   assign setup_phase  = psel & ~penable;
   assign access_phase = psel & penable;
   assign hit_ctrl     = (paddr == pbsps_pkg::OFS_CTRL);
   assign hit_duty     = (paddr == pbsps_pkg::OFS_DUTY);
   assign hit_capture  = (paddr == pbsps_pkg::OFS_CAPTURE);
   assign hit_status   = (paddr == pbsps_pkg::OFS_STATUS);
   assign hit_port     = (paddr == pbsps_pkg::OFS_PORT);
   assign hit_mask     = (paddr == pbsps_pkg::OFS_MASK);
   assign hit_any      = hit_ctrl | hit_duty | hit_capture | hit_status
                       | hit_port | hit_mask;
   assign wr_en        = access_phase & pwrite;
   // Zero wait states; unmapped addresses answer with an error
   assign pready       = 1'b1;
   assign pslverr      = access_phase & ~hit_any;
   assign prdata       = prdata_ff;

   // Read mux, sampled in the setup cycle
   always_comb begin
      nxt_prdata = prdata_ff;
      if (setup_phase & ~pwrite) begin
         nxt_prdata = '0;
         if (hit_ctrl) begin
            nxt_prdata[pbsps_pkg::CTRL_W-1:0] = ctrl_ff;
         end else if (hit_duty) begin
            nxt_prdata[pbsps_pkg::DUTY_W-1:0] = duty_ff;
         end else if (hit_capture) begin
            nxt_prdata[pbsps_pkg::CNT_W-1:0] = capture_ff;
         end else if (hit_status) begin
            nxt_prdata[pbsps_pkg::IRQ_W-1:0] = status_ff;
         end else if (hit_port) begin
            nxt_prdata[pbsps_pkg::PORT_OUT_BIT] = port_out_ff;
            nxt_prdata[pbsps_pkg::PORT_IN_BIT]  = port_in_level; // RQ7
         end else if (hit_mask) begin
            nxt_prdata[pbsps_pkg::IRQ_W-1:0] = mask_ff;
         end
      end
   end

   // ---------------------------------------------------------------
   // Register writes, capture and interrupt status
   // ---------------------------------------------------------------
   logic [pbsps_pkg::IRQ_W-1:0] status_clear;
   logic [pbsps_pkg::IRQ_W-1:0] status_set;

   assign nxt_ctrl     = (wr_en & hit_ctrl) ?
                         pwdata[pbsps_pkg::CTRL_W-1:0] : ctrl_ff;
   assign nxt_duty     = (wr_en & hit_duty) ?
                         pwdata[pbsps_pkg::DUTY_W-1:0] : duty_ff;
   assign nxt_mask     = (wr_en & hit_mask) ?
                         pwdata[pbsps_pkg::IRQ_W-1:0] : mask_ff;
   assign nxt_port_out = (wr_en & hit_port) ?
                         pwdata[pbsps_pkg::PORT_OUT_BIT] : port_out_ff; // RQ7
   // Capture loads regardless of the mask
   assign nxt_capture  = capture_edge ? timer_count : capture_ff; // RQ1
   assign status_set   = {{(pbsps_pkg::IRQ_W-1){1'b0}}, capture_edge};
   assign status_clear = (wr_en & hit_status) ?
                         pwdata[pbsps_pkg::IRQ_W-1:0] : '0;
   // Set wins over a write-one clear in the same cycle
   assign nxt_status   = (status_ff & ~status_clear) | status_set; // RQ1
   // Level request while any unmasked status bit stands
   assign capture_interrupt_request = |(status_ff & mask_ff); // RQ3
   assign capture_vector = pbsps_pkg::CAPTURE_VECTOR;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_ff     <= pbsps_pkg::RST_CTRL;
         duty_ff     <= pbsps_pkg::RST_DUTY;
         mask_ff     <= pbsps_pkg::RST_MASK;
         port_out_ff <= pbsps_pkg::RST_PORT_OUT;
         capture_ff  <= '0;
         status_ff   <= '0;
         prdata_ff   <= '0;
         level_ff    <= '0;
      end else begin
         ctrl_ff     <= nxt_ctrl;
         duty_ff     <= nxt_duty;
         mask_ff     <= nxt_mask;
         port_out_ff <= nxt_port_out;
         capture_ff  <= nxt_capture;
         status_ff   <= nxt_status;
         prdata_ff   <= nxt_prdata;
         level_ff    <= nxt_level;
      end
   end

   // ---------------------------------------------------------------
   // First PWM: divider enable, free counter, duty compare
   // ---------------------------------------------------------------
   logic                        freq_sel;
   logic [pbsps_pkg::DIV_W-1:0] div_limit;
   logic                        pwm_tick;

   assign freq_sel    = ctrl_ff[pbsps_pkg::CTRL_FREQ_SEL];
   assign div_limit   = freq_sel ? DIV_SLOW_LIM : DIV_FAST_LIM; // RQ6
   assign pwm_tick    = (div_ff >= div_limit);
   assign nxt_div     = pwm_tick ? '0 : div_ff + 1'b1;
   assign nxt_pwm_cnt = pwm_tick ? pwm_cnt_ff + 1'b1 : pwm_cnt_ff;
   assign nxt_pwm     = (pwm_cnt_ff < duty_ff); // RQ6

   // Shared pin selects port bit or waveform
   assign nxt_shared_out = ctrl_ff[pbsps_pkg::CTRL_OUT_SEL] ?
                           pwm_ff :          // RQ5
                           port_out_ff;      // RQ4
   assign shared_output_pin = shared_out_ff;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         div_ff        <= '0;
         pwm_cnt_ff    <= '0;
         pwm_ff        <= 1'b0;
         shared_out_ff <= pbsps_pkg::RST_PORT_OUT;
      end else begin
         div_ff        <= nxt_div;
         pwm_cnt_ff    <= nxt_pwm_cnt;
         pwm_ff        <= nxt_pwm;
         shared_out_ff <= nxt_shared_out;
      end
   end

   // ---------------------------------------------------------------
   // Write strobes for the external multiplexed bus
   // ---------------------------------------------------------------
   logic strobe_mode;
   logic ext_write;
   logic write_strobe_n;
   logic high_byte_enable_n;
   logic low_byte_write_strobe_n;
   logic high_byte_write_strobe_n;

   assign strobe_mode = ctrl_ff[pbsps_pkg::CTRL_STB_MODE];
   // Only external writes strobe; reads and internal cycles never do
   assign ext_write   = bus_req.ext & bus_req.wr; // RQ9
   assign write_strobe_n = ~ext_write; // RQ9
   assign high_byte_enable_n =
      ~(ext_write & (bus_req.word | bus_req.hi_byte)); // RQ10
   assign low_byte_write_strobe_n =
      ~(ext_write & (~bus_req.wide | bus_req.word | ~bus_req.hi_byte)); // RQ11
   assign high_byte_write_strobe_n =
      ~(ext_write & (~bus_req.wide                                   // RQ13
                     | bus_req.word | bus_req.hi_byte));             // RQ12
   // Mode bit picks which pair drives the two pins
   assign nxt_pin_a_n = strobe_mode ? write_strobe_n :
                        low_byte_write_strobe_n; // RQ8
   assign nxt_pin_b_n = strobe_mode ? high_byte_enable_n :
                        high_byte_write_strobe_n; // RQ8
   assign strobe_pin_a_n = pin_a_n_ff;
   assign strobe_pin_b_n = pin_b_n_ff;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pin_a_n_ff <= 1'b1;
         pin_b_n_ff <= 1'b1;
      end else begin
         pin_a_n_ff <= nxt_pin_a_n;
         pin_b_n_ff <= nxt_pin_b_n;
      end
   end

   // ---------------------------------------------------------------
   // Assertions and covers
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   a_capture_load: assert property ( // RQ1
      capture_edge |=> capture_ff == $past(timer_count))
      else $error("Capture register missed the timer count");
   a_capture_flag: assert property ( // RQ1
      capture_edge |=> status_ff[pbsps_pkg::IRQ_CAPTURE])
      else $error("Capture edge did not set the status bit");
   a_mask_gates_irq: assert property ( // RQ3
      !mask_ff[pbsps_pkg::IRQ_CAPTURE] |-> !capture_interrupt_request)
      else $error("Masked capture raised the interrupt");
   a_port_drives_pin: assert property ( // RQ4
      !ctrl_ff[pbsps_pkg::CTRL_OUT_SEL] |=>
         shared_output_pin == $past(port_out_ff))
      else $error("Shared pin not following port bit five");
   a_pwm_drives_pin: assert property ( // RQ5
      ctrl_ff[pbsps_pkg::CTRL_OUT_SEL] |=>
         shared_output_pin == $past(pwm_ff))
      else $error("Shared pin not following the waveform");
   a_zero_duty_low: assert property ( // RQ6
      (duty_ff == '0) [*2] |-> !pwm_ff)
      else $error("Waveform high with zero duty");
   a_port_read_in: assert property ( // RQ7
      setup_phase && !pwrite && hit_port |=>
         prdata[pbsps_pkg::PORT_IN_BIT] == $past(port_in_level))
      else $error("Port read lost input bit four");
   a_combined_write: assert property ( // RQ9
      strobe_mode && !ext_write |=> strobe_pin_a_n)
      else $error("Write strobe outside an external write");
   a_combined_bhe: assert property ( // RQ10
      strobe_mode && ext_write && bus_req.word |=> !strobe_pin_b_n)
      else $error("High enable missing on word write");
   a_split_low: assert property ( // RQ11
      !strobe_mode && ext_write && !bus_req.wide |=> !strobe_pin_a_n)
      else $error("Low strobe missing on narrow bus write");
   a_split_high16: assert property ( // RQ12
      !strobe_mode && ext_write && bus_req.wide && bus_req.hi_byte
      |=> !strobe_pin_b_n)
      else $error("High strobe missing on high-byte write");
   a_split_high8: assert property ( // RQ13
      !strobe_mode && ext_write && !bus_req.wide |=> !strobe_pin_b_n)
      else $error("High strobe missing on narrow bus write");
   a_edge_filtered: assert property ( // RQ14
      $rose(level_ff[0]) |-> $past(capture_edge))
      else $error("Capture level rose without an edge");
   a_combined_hi_byte: assert property ( // RQ10
      strobe_mode && ext_write && bus_req.hi_byte |=> !strobe_pin_b_n)
      else $error("High enable missing on high-byte write");
   a_split_low_word: assert property ( // RQ11
      !strobe_mode && ext_write && bus_req.word |=> !strobe_pin_a_n)
      else $error("Low strobe missing on word write");
   a_split_idle: assert property ( // RQ11
      !strobe_mode && !ext_write |=> strobe_pin_a_n && strobe_pin_b_n)
      else $error("Split strobe outside an external write");
   a_irq_unmasked: assert property ( // RQ3
      status_ff[pbsps_pkg::IRQ_CAPTURE] && mask_ff[pbsps_pkg::IRQ_CAPTURE]
      |-> capture_interrupt_request)
      else $error("Unmasked capture status without interrupt");
   a_status_sticky: assert property ( // RQ1
      status_ff[pbsps_pkg::IRQ_CAPTURE]
      && !status_clear[pbsps_pkg::IRQ_CAPTURE]
      |=> status_ff[pbsps_pkg::IRQ_CAPTURE])
      else $error("Capture status dropped without a clear");

   c_capture_irq: cover property (
      capture_edge && mask_ff[pbsps_pkg::IRQ_CAPTURE]);
   c_set_and_clear: cover property (
      capture_edge && status_clear[pbsps_pkg::IRQ_CAPTURE]);
   c_pwm_on_pin: cover property (
      ctrl_ff[pbsps_pkg::CTRL_OUT_SEL] && $rose(shared_output_pin));
   c_split_word: cover property (
      !strobe_mode && ext_write && bus_req.wide && bus_req.word);
   c_combined_hi: cover property (
      strobe_mode && ext_write && bus_req.hi_byte);

endmodule : pbsps_top

// >>> dv/pbsps_ext_model.sv
// Far-side model: capture source, port input pin and strobe pin A watcher
`timescale 1ns/1ns
module pbsps_ext_model (
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic fire,
   input  wire logic pin_level,
   input  wire logic strobe_a_n,
   output logic      cap_pin,
   output logic      port_pin,
   output int        a_low_cnt
);
   int hold_cnt = 0;

   // Capture pulse held high three cycles on each request
   always @(posedge mclk) begin
      if (fire) hold_cnt <= 3;
      else if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
   end
   assign cap_pin  = (hold_cnt > 0);
   assign port_pin = pin_level;

   // Memory side counts cycles with strobe pin A active (low strobe in split mode, write strobe in combined mode)
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) a_low_cnt <= 0;
      else if (!strobe_a_n) a_low_cnt <= a_low_cnt + 1;
   end
endmodule : pbsps_ext_model

// >>> dv/port2_bus_strobe_pin_select_bench.sv
// Self-checking bench of the port-two pin block
`timescale 1ns/1ns
module port2_bus_strobe_pin_select_bench;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] tcnt = 16'h0, vec;
   logic        pready, pslverr, pin, sa_n, sb_n, irq, cap, pin4, err;
   logic        fire = 0, lvl = 0, ea, eb, w;
   logic [4:0]  q;
   logic [7:0]  duty;
   logic [1:0]  pair;
   logic [1:0]  exp_q[$];
   pbsps_pkg::pbsps_bus_t breq = 5'h00;
   int          failures = 0, samples_checked = 0, acnt, exp_a = 0, hi;

   always #5 mclk = ~mclk;

   pbsps_top #(.PWM_DIV_FAST(1), .PWM_DIV_SLOW(2)) DUT (
      .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer_count(tcnt),
      .bus_req(breq), .timer_two_capture_input(cap),
      .port_two_input_bit_four(pin4), .shared_output_pin(pin),
      .strobe_pin_a_n(sa_n), .strobe_pin_b_n(sb_n),
      .capture_interrupt_request(irq), .capture_vector(vec));

   pbsps_ext_model ext (.mclk(mclk), .rstn(rstn), .fire(fire),
      .pin_level(lvl), .strobe_a_n(sa_n), .cap_pin(cap),
      .port_pin(pin4), .a_low_cnt(acnt));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task results;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results

   task chk_w(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("unexpected t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk_w

   task chk_b(input logic g, input logic e);
      chk_w({31'h0, g}, {31'h0, e});
   endtask : chk_b

   // One APB transfer, released only after pready is seen high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      n = 0;
      do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin failures++; results(); end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb

   task rdc(input logic [7:0] a, input logic [31:0] e);
      apb(0, a, 32'h0);
      chk_w(rd, e);
   endtask : rdc

   task wait_c(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : wait_c

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'hf990));
      repeat (20) @(posedge mclk);
      rstn <= 1;
      // Reset values and refused accesses
      rdc(pbsps_pkg::OFS_CTRL, 32'h0);
      rdc(pbsps_pkg::OFS_DUTY, 32'h0);
      rdc(pbsps_pkg::OFS_STATUS, 32'h0);
      rdc(pbsps_pkg::OFS_MASK, 32'h0);
      apb(1, pbsps_pkg::OFS_CAPTURE, 32'h1234);
      rdc(pbsps_pkg::OFS_CAPTURE, 32'h0);
      apb(0, pbsps_pkg::OFS_PORT, 32'h0);
      chk_b(err, 1'b0);
      chk_b(rd[5], 1'b1);
      chk_b(pin, 1'b1);
      apb(1, 8'h18, 32'hffff_ffff);
      chk_b(err, 1'b1);
      $display("test reset done");
      // Port bit five drives the pin, bit four reads the input
      repeat (4) begin
         q = 5'($urandom);
         apb(1, pbsps_pkg::OFS_PORT, {26'h0, q[0], q[2], 4'h0});
         lvl <= q[1];
         wait_c(5);
         chk_b(pin, q[0]);
         apb(0, pbsps_pkg::OFS_PORT, 32'h0);
         chk_b(rd[5], q[0]);
         chk_b(rd[4], q[1]);
      end
      $display("test port done");
      // PWM on the pin: high cycles per period follow duty and divider
      for (int f = 0; f < 2; f++) begin
         duty = 8'($urandom_range(1, 255));
         apb(1, pbsps_pkg::OFS_DUTY, {24'h0, duty});
         apb(1, pbsps_pkg::OFS_CTRL, {30'h0, f[0], 1'b1});
         wait_c(520);
         hi = 0;
         repeat (256 * (f + 1)) begin @(posedge mclk); #1; hi += pin; end
         chk_w(hi, duty * (f + 1));
      end
      $display("test pwm done");
      // Every bus cycle kind in both strobe modes
      for (int i = 0; i < 64; i++) begin
         if (i == 0 || i == 32)
            apb(1, pbsps_pkg::OFS_CTRL, {29'h0, i[5], 2'h0});
         q = 5'(i);
         w  = q[4] & q[3];
         ea = !(w & (i[5] | !q[2] | q[1] | !q[0]));
         eb = !(w & (i[5] ? (q[1] | q[0]) : (!q[2] | q[1] | q[0])));
         exp_q.push_back({ea, eb});
         exp_a += !ea;
         @(posedge mclk);
         breq <= q;
         @(posedge mclk);
         breq <= 5'h00;
         #1;
         pair = exp_q.pop_front();
         chk_b(sa_n, pair[1]);
         chk_b(sb_n, pair[0]);
      end
      wait_c(2);
      chk_w(acnt, exp_a);
      $display("test strobes done");
      // Capture with the interrupt masked, then unmasked
      for (int m = 0; m < 2; m++) begin
         @(posedge mclk);
         tcnt <= 16'($urandom);
         apb(1, pbsps_pkg::OFS_MASK, m);
         fire <= 1;
         @(posedge mclk);
         fire <= 0;
         wait_c(8);
         chk_b(irq, m[0]);
         rdc(pbsps_pkg::OFS_CAPTURE, {16'h0, tcnt});
         rdc(pbsps_pkg::OFS_STATUS, 32'h1);
         chk_w({16'h0, vec}, 32'h2036);
         apb(1, pbsps_pkg::OFS_STATUS, 32'h1);
         rdc(pbsps_pkg::OFS_STATUS, 32'h0);
         wait_c(2);
         chk_b(irq, 1'b0);
      end
      $display("test capture done");
      results();
   end
endmodule : port2_bus_strobe_pin_select_bench
